// file: hw/motor_debug_pkg.sv
// Purpose: Shared constants for the algorithm debug speed_source_select register.
// Assumes: Byte offsets as printed; fields of one 32-bit word.
// Notes:   Startup method codes and state codes are local choices.
package motor_debug_pkg;

    // Register map.
    localparam logic [8:0]  SPEED_SOURCE_SELECT_OFFSET = 9'h0ec;
    localparam logic [31:0] SPEED_SOURCE_SELECT_RESET  = 32'h0000_0000;

    // Field positions inside the speed_source_select word.
    localparam int SPEED_SRC_BIT   = 31;
    localparam int SPEED_CMD_MSB   = 30;
    localparam int SPEED_CMD_LSB   = 16;
    localparam int CLOSED_OFF_BIT  = 15;
    localparam int HOLD_ALIGN_BIT  = 14;
    localparam int HOLD_SLOW_BIT   = 13;
    localparam int HOLD_POLE_BIT   = 12;
    localparam int HOLD_SPEED_BIT  = 11;
    localparam int ANGLE_SRC_BIT   = 10;
    localparam int IQ_CODE_MSB     = 9;
    localparam int IQ_CODE_LSB     = 0;

    // Speed input selection value that also routes the register command.
    localparam logic [1:0] SPEED_INPUT_REGISTER = 2'h2;

    // Startup method encodings.
    localparam logic [1:0] METHOD_ALIGN        = 2'h0;
    localparam logic [1:0] METHOD_DOUBLE_ALIGN = 2'h1;
    localparam logic [1:0] METHOD_POLE_DETECT  = 2'h2;
    localparam logic [1:0] METHOD_SLOW_FIRST   = 2'h3;

    // Angle wrap and torque current scaling.
    localparam logic [8:0] ANGLE_WRAP      = 9'h168;
    localparam int         FULL_SCALE_MA   = 6250;
    localparam int         CODE_FULL_SCALE = 500;
    localparam int         IQ_STEP_HALF_MA = 2 * FULL_SCALE_MA
                                             / CODE_FULL_SCALE;

    // Startup sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE        = 7'h01,
        ST_SPEED_DET   = 7'h02,
        ST_POLE_DET    = 7'h04,
        ST_ALIGN       = 7'h08,
        ST_SLOW_FIRST  = 7'h10,
        ST_OPEN_LOOP   = 7'h20,
        ST_CLOSED_LOOP = 7'h40
    } seq_state_t;

endpackage : motor_debug_pkg

// file: hw/torque_code_scaler.sv
// Purpose: Turns the 10-bit torque current code into a signed reference.
// Assumes: Output unit is half a milliamp; one code step is 12.5 mA.
// Notes:   Codes 501 to 511 are not valid and simply scale linearly.
`timescale 1ns/100ps
module torque_code_scaler
(
    input  wire logic               ref_clk,   // System clock.
    input  wire logic               reset,     // Synchronous, active high.
    input  wire logic [9:0]         code,      // Torque current code.
    output logic signed [15:0]      iq_ref_q   // Reference, 0.5 mA units.
);

    ////////////////////////////////////////////////////////////////////////
    // Codes from 512 up mean code minus 1024; that is exactly the sign
    // extension of the 10-bit code, so no subtractor is needed.
    wire logic signed [15:0] code_signed;
    wire logic signed [31:0] product;
    assign code_signed = {{6{code[9]}}, code};
    assign product     = 32'(code_signed * 16'sd25);

    // Registered so the reference changes cleanly once per write.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            iq_ref_q <= 16'sh0000;
        else
            iq_ref_q <= product[15:0];
    end

    ////////////////////////////////////////////////////////////////////////
    a_iq_positive_scale: assert property (
        @(posedge ref_clk) disable iff (reset)
        (code < 10'h200) |=> (iq_ref_q == 16'($past(code)) * 16'd25))
        else $error("Positive torque reference scaled wrongly.");

    a_iq_negative_scale: assert property (
        @(posedge ref_clk) disable iff (reset)
        (code > 10'h200) |=>
        (iq_ref_q == 16'((32'($past(code)) - 32'd1024) * 32'sd25)))
        else $error("Negative torque reference scaled wrongly.");

endmodule : torque_code_scaler

// file: hw/motor_algo_debug_speed_source_select_regs.sv
// Purpose: Write-only debug speed_source_select register and the startup sequencer
//          and reference selection that it steers.
// Assumes: Register writes arrive from the serial target on ref_clk.
// Notes:   All algorithm inputs are on ref_clk; no synchronisers needed.
// Behaviour
// - Bit 31 picks configured or register speed.
// - Register speed used if selected or mode 10b.
// - Bit 15 forces open loop commutation.
// - Bit 14 holds align for align methods.
// - Bit 13 holds slow first cycle state.
// - Bit 12 holds initial position detection state.
// - Bit 11 holds initial speed detection state.
// - Bit 10 picks configured or debug angle.
// - Codes below 512 give positive scaled current.
// - Codes from 512 up give code minus 1024.
// - Register at ECh, resets zero, write only.
// - Debug angle is applied modulo 360 degrees.
`timescale 1ns/100ps
module motor_algo_debug_speed_source_select_regs
(
    input  wire logic        ref_clk,              // 10 MHz system clock.
    input  wire logic        reset,                // Synchronous, high.
    input  wire logic        reg_wr_en,            // Register write strobe.
    input  wire logic [8:0]  reg_addr,             // Register byte offset.
    input  wire logic [31:0] reg_wdata,            // Register write data.
    input  wire logic [1:0]  speed_input_select,   // Speed input mode.
    input  wire logic [14:0] configured_speed,     // Speed from input pin.
    input  wire logic [1:0]  startup_method,       // Startup method code.
    input  wire logic        speed_detect_enable,  // Speed detect first.
    input  wire logic        speed_loop_off,       // Speed loop bypassed.
    input  wire logic [8:0]  configured_align_angle, // Preset angle.
    input  wire logic [8:0]  debug_align_angle,    // Control reg angle.
    input  wire logic        start_req,            // Start the motor.
    input  wire logic        stop_req,             // Stop the motor.
    input  wire logic        phase_done,           // Current phase done.
    output logic [14:0]      speed_ref_q,          // Chosen speed ref.
    output logic [8:0]       align_angle_q,        // Chosen align angle.
    output logic signed [15:0] iq_ref,             // Torque ref, 0.5 mA.
    output logic             iq_speed_source_select_q,        // Torque ref in force.
    output logic [6:0]       seq_state_q           // One-hot startup state.
);

    ////////////////////////////////////////////////////////////////////////
    // The speed_source_select word. No read path exists: software cannot read back.
    logic [31:0] speed_source_select_q;
    wire  logic  wr_hit;
    assign wr_hit = reg_wr_en &&
                    (reg_addr == motor_debug_pkg::SPEED_SOURCE_SELECT_OFFSET);

    // Whole-word write; fields hold between writes.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            speed_source_select_q <= motor_debug_pkg::SPEED_SOURCE_SELECT_RESET;
        else if (wr_hit)
            speed_source_select_q <= reg_wdata;
    end

    // Field decode.
    wire logic        speed_src;
    wire logic [14:0] speed_cmd;
    wire logic        closed_off;
    wire logic        hold_align;
    wire logic        hold_slow;
    wire logic        hold_pole;
    wire logic        hold_speed;
    wire logic        angle_src;
    wire logic [9:0]  iq_code;
    assign speed_src  = speed_source_select_q[motor_debug_pkg::SPEED_SRC_BIT];
    assign speed_cmd  = speed_source_select_q[motor_debug_pkg::SPEED_CMD_MSB:
                                   motor_debug_pkg::SPEED_CMD_LSB];
    assign closed_off = speed_source_select_q[motor_debug_pkg::CLOSED_OFF_BIT];
    assign hold_align = speed_source_select_q[motor_debug_pkg::HOLD_ALIGN_BIT];
    assign hold_slow  = speed_source_select_q[motor_debug_pkg::HOLD_SLOW_BIT];
    assign hold_pole  = speed_source_select_q[motor_debug_pkg::HOLD_POLE_BIT];
    assign hold_speed = speed_source_select_q[motor_debug_pkg::HOLD_SPEED_BIT];
    assign angle_src  = speed_source_select_q[motor_debug_pkg::ANGLE_SRC_BIT];
    assign iq_code    = speed_source_select_q[motor_debug_pkg::IQ_CODE_MSB:
                                   motor_debug_pkg::IQ_CODE_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Reference selection. The register command wins when asked for either
    // by the speed_source_select bit or by the speed input mode itself.
    wire logic        use_cmd;
    wire logic [14:0] speed_ref_d;
    wire logic [8:0]  angle_wrapped;
    wire logic [8:0]  align_angle_d;
    assign use_cmd = speed_src ||
        (speed_input_select == motor_debug_pkg::SPEED_INPUT_REGISTER);
    assign speed_ref_d = use_cmd ? speed_cmd : configured_speed;
    // A 9-bit angle is at most 511, so one subtraction is a full modulo.
    assign angle_wrapped =
        (debug_align_angle >= motor_debug_pkg::ANGLE_WRAP) ?
        debug_align_angle - motor_debug_pkg::ANGLE_WRAP :
        debug_align_angle;
    assign align_angle_d = angle_src ? angle_wrapped :
                           configured_align_angle;

    // References leave through flops so the algorithm sees stable values.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            speed_ref_q   <= 15'h0000;
            align_angle_q <= 9'h000;
            iq_speed_source_select_q <= 1'b0;
        end
        else
        begin
            speed_ref_q   <= speed_ref_d;
            align_angle_q <= align_angle_d;
            iq_speed_source_select_q <= speed_loop_off;
        end
    end

    // Torque current code scaling; held code acts while the loop is off.
    torque_code_scaler u_scaler
    (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .code     (iq_code),
        .iq_ref_q (iq_ref)
    );

    ////////////////////////////////////////////////////////////////////////
    // Startup sequencer. Each startup phase ends on phase_done unless its
    // hold bit is set; the holds only matter in the state they name.
    motor_debug_pkg::seq_state_t state_q;
    motor_debug_pkg::seq_state_t state_d;
    motor_debug_pkg::seq_state_t first_state;
    assign first_state =
        (startup_method == motor_debug_pkg::METHOD_POLE_DETECT) ?
            motor_debug_pkg::ST_POLE_DET :
        (startup_method == motor_debug_pkg::METHOD_SLOW_FIRST) ?
            motor_debug_pkg::ST_SLOW_FIRST : motor_debug_pkg::ST_ALIGN;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            motor_debug_pkg::ST_IDLE:
                if (start_req)
                    state_d = speed_detect_enable ?
                              motor_debug_pkg::ST_SPEED_DET : first_state;
            motor_debug_pkg::ST_SPEED_DET:
                if (phase_done && !hold_speed)
                    state_d = first_state;
            motor_debug_pkg::ST_POLE_DET:
                if (phase_done && !hold_pole)
                    state_d = motor_debug_pkg::ST_OPEN_LOOP;
            motor_debug_pkg::ST_ALIGN:
                if (phase_done && !hold_align)
                    state_d = motor_debug_pkg::ST_OPEN_LOOP;
            motor_debug_pkg::ST_SLOW_FIRST:
                if (phase_done && !hold_slow)
                    state_d = motor_debug_pkg::ST_OPEN_LOOP;
            motor_debug_pkg::ST_OPEN_LOOP:
                if (phase_done && !closed_off)
                    state_d = motor_debug_pkg::ST_CLOSED_LOOP;
            motor_debug_pkg::ST_CLOSED_LOOP:
                if (closed_off)
                    state_d = motor_debug_pkg::ST_OPEN_LOOP;
            default:
                state_d = motor_debug_pkg::ST_IDLE;
        endcase
        // Stop overrides every hold so the motor can always be halted.
        if (stop_req)
            state_d = motor_debug_pkg::ST_IDLE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            state_q <= motor_debug_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    assign seq_state_q = state_q;

    ////////////////////////////////////////////////////////////////////////
    a_write_loads_word: assert property (
        @(posedge ref_clk) disable iff (reset)
        (reg_wr_en && reg_addr == 9'h0ec) |=>
        (speed_source_select_q == $past(reg_wdata)))
        else $error("Speed_source_select word not loaded on write.");

    a_fields_hold_value: assert property (
        @(posedge ref_clk) disable iff (reset)
        !(reg_wr_en && reg_addr == 9'h0ec) |=> $stable(speed_source_select_q))
        else $error("Speed_source_select word changed without a write.");

    a_speed_from_cmd: assert property (
        @(posedge ref_clk) disable iff (reset)
        speed_source_select_q[31] |=> (speed_ref_q == $past(speed_source_select_q[30:16])))
        else $error("Register speed command not selected.");

    a_speed_mode_cmd: assert property (
        @(posedge ref_clk) disable iff (reset)
        (speed_input_select == 2'h2) |=>
        (speed_ref_q == $past(speed_source_select_q[30:16])))
        else $error("Speed mode 10b did not route the command.");

    a_speed_from_input: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!speed_source_select_q[31] && speed_input_select != 2'h2) |=>
        (speed_ref_q == $past(configured_speed)))
        else $error("Configured speed not selected.");

    a_debug_angle_wrap: assert property (
        @(posedge ref_clk) disable iff (reset)
        (speed_source_select_q[10] && debug_align_angle >= 9'h168) |=>
        (align_angle_q == $past(debug_align_angle) - 9'h168))
        else $error("Debug angle not wrapped at 360.");

    a_config_angle_used: assert property (
        @(posedge ref_clk) disable iff (reset)
        !speed_source_select_q[10] |=> (align_angle_q == $past(configured_align_angle)))
        else $error("Configured align angle not selected.");

    a_align_stays_held: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_q == motor_debug_pkg::ST_ALIGN && speed_source_select_q[14] &&
         !stop_req) |=> (state_q == motor_debug_pkg::ST_ALIGN))
        else $error("Align state left while held.");

    a_slow_stays_held: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_q == motor_debug_pkg::ST_SLOW_FIRST && speed_source_select_q[13] &&
         !stop_req) |=> (state_q == motor_debug_pkg::ST_SLOW_FIRST))
        else $error("Slow first cycle left while held.");

    a_pole_stays_held: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_q == motor_debug_pkg::ST_POLE_DET && speed_source_select_q[12] &&
         !stop_req) |=> (state_q == motor_debug_pkg::ST_POLE_DET))
        else $error("Position detection left while held.");

    a_speed_det_held: assert property (
        @(posedge ref_clk) disable iff (reset)
        (state_q == motor_debug_pkg::ST_SPEED_DET && speed_source_select_q[11] &&
         !stop_req) |=> (state_q == motor_debug_pkg::ST_SPEED_DET))
        else $error("Speed detection left while held.");

    a_open_loop_forced: assert property (
        @(posedge ref_clk) disable iff (reset)
        (speed_source_select_q[15] && !stop_req &&
         (state_q == motor_debug_pkg::ST_OPEN_LOOP ||
          state_q == motor_debug_pkg::ST_CLOSED_LOOP)) |=>
        (state_q == motor_debug_pkg::ST_OPEN_LOOP))
        else $error("Closed loop reached while disabled.");

endmodule : motor_algo_debug_speed_source_select_regs

// file: verification/speed_source_select_writer.sv
// Purpose: Stand-in for the external controller that writes the speed_source_select.
// Assumes: One whole 32-bit word per write, strobe held for one edge.
// Notes:   Address and data are inverted when idle so stale values show.
`timescale 1ns/100ps
module speed_source_select_writer
(
    input  wire logic        ref_clk,    // System clock.
    output logic             reg_wr_en,  // Write strobe.
    output logic [8:0]       reg_addr,   // Byte offset of the write.
    output logic [31:0]      reg_wdata   // Whole write word.
);

    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero, nothing requested.
    initial
    begin
        reg_wr_en = 1'b0;
        reg_addr  = 9'h000;
        reg_wdata = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // One write, launched just after an edge and taken at the next one.
    // Torque codes outside the legal ranges are replaced by zero, since a
    // real controller must never send them and the device need not cope.
    task automatic write_word(input logic [8:0] addr,
                              input logic [31:0] data);
        logic [9:0] code;
        code = data[9:0];
        if ((code > 10'h1f4 && code < 10'h200) || code > 10'h3e8)
            data[9:0] = 10'h000;
        @(posedge ref_clk);
        #10;
        reg_wr_en = 1'b1;
        reg_addr  = addr;
        reg_wdata = data;
        @(posedge ref_clk);
        #10;
        reg_wr_en = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask : write_word

endmodule : speed_source_select_writer

// file: verification/testbench.sv
// Purpose: Self-checking bench for the algorithm debug speed_source_select register.
// Assumes: Inputs change 10 ns after the rising edge of a 100 ns clock.
// Notes:   The writer model is driven through its task by hierarchy.
`timescale 1ns/100ps
module testbench;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic              reg_wr_en;
    logic [8:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic [1:0]        speed_input_select = 2'h0;
    logic [14:0]       configured_speed = 15'h0000;
    logic [1:0]        startup_method = 2'h0;
    logic              speed_detect_enable = 1'b0;
    logic              speed_loop_off = 1'b0;
    logic [8:0]        configured_align_angle = 9'h000;
    logic [8:0]        debug_align_angle = 9'h000;
    logic              start_req = 1'b0;
    logic              stop_req = 1'b0;
    logic              phase_done = 1'b0;
    logic [14:0]       speed_ref_q;
    logic [8:0]        align_angle_q;
    logic signed [15:0] iq_ref;
    logic              iq_speed_source_select_q;
    logic [6:0]        seq_state_q;
    int                err_total = 0;
    int                total_checks = 0;
    int                cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and controller model.
    always #50 ref_clk = ~ref_clk;

    motor_algo_debug_speed_source_select_regs i_dut (.ref_clk(ref_clk), .reset(reset),
        .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .speed_input_select(speed_input_select),
        .configured_speed(configured_speed), .startup_method(startup_method),
        .speed_detect_enable(speed_detect_enable),
        .speed_loop_off(speed_loop_off),
        .configured_align_angle(configured_align_angle),
        .debug_align_angle(debug_align_angle), .start_req(start_req),
        .stop_req(stop_req), .phase_done(phase_done),
        .speed_ref_q(speed_ref_q), .align_angle_q(align_angle_q),
        .iq_ref(iq_ref), .iq_speed_source_select_q(iq_speed_source_select_q),
        .seq_state_q(seq_state_q));

    speed_source_select_writer i_writer (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers: step past an edge, compare, close the run.
    task automatic tick;
        @(posedge ref_clk);
        #10;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic test_reset;
        reset = 1'b1;
        repeat (4) tick;
        reset = 1'b0;
        chk(speed_ref_q, 32'h0);
        chk(align_angle_q, 32'h0);
        chk({16'h0000, iq_ref}, 32'h0);
        chk(seq_state_q, motor_debug_pkg::ST_IDLE);
    endtask : test_reset

    task automatic test_speed;
        configured_speed = 15'h0123;
        i_writer.write_word(9'h0ec, 32'h8005_0000);
        repeat (2) tick;
        chk(speed_ref_q, 32'h0005);
        i_writer.write_word(9'h0ee, 32'h8009_0000);
        repeat (2) tick;
        chk(speed_ref_q, 32'h0005);
        i_writer.write_word(9'h0ec, 32'h0007_0000);
        repeat (2) tick;
        chk(speed_ref_q, 32'h0123);
        speed_input_select = 2'h2;
        repeat (2) tick;
        chk(speed_ref_q, 32'h0007);
        speed_input_select = 2'h0;
    endtask : test_speed

    task automatic test_torque;
        logic [9:0]         codes [6] = '{10'h000, 10'h001, 10'h1f4,
                                          10'h200, 10'h201, 10'h3e8};
        logic signed [15:0] exp;
        speed_loop_off = 1'b1;
        foreach (codes[i])
        begin
            exp = codes[i] < 10'h200 ? 16'(16'(codes[i]) * 25)
                                     : 16'((32'(codes[i]) - 1024) * 25);
            i_writer.write_word(9'h0ec, {22'h0, codes[i]});
            repeat (2) tick;
            chk({16'h0000, iq_ref}, {16'h0000, exp});
            chk(iq_speed_source_select_q, 32'h1);
        end
        speed_loop_off = 1'b0;
        repeat (2) tick;
        chk(iq_speed_source_select_q, 32'h0);
    endtask : test_torque

    task automatic test_angle;
        configured_align_angle = 9'h05a;
        debug_align_angle = 9'h1f4;
        i_writer.write_word(9'h0ec, 32'h0000_0000);
        repeat (2) tick;
        chk(align_angle_q, 32'h05a);
        i_writer.write_word(9'h0ec, 32'h0000_0400);
        repeat (2) tick;
        chk(align_angle_q, 32'h08c);
        debug_align_angle = 9'h168;
        repeat (2) tick;
        chk(align_angle_q, 32'h000);
        debug_align_angle = 9'h0b4;
        repeat (2) tick;
        chk(align_angle_q, 32'h0b4);
    endtask : test_angle

    // Holds a startup state with its bit set, then releases it.
    task automatic test_hold(input logic [1:0] method, input logic sde,
        input logic [31:0] word, input logic [6:0] held,
        input logic [6:0] after);
        startup_method = method;
        speed_detect_enable = sde;
        i_writer.write_word(9'h0ec, word);
        start_req = 1'b1;
        tick;
        start_req = 1'b0;
        tick;
        chk(seq_state_q, held);
        phase_done = 1'b1;
        repeat (3) tick;
        phase_done = 1'b0;
        chk(seq_state_q, held);
        i_writer.write_word(9'h0ec, 32'h0000_0000);
        phase_done = 1'b1;
        tick;
        phase_done = 1'b0;
        tick;
        chk(seq_state_q, after);
        stop_req = 1'b1;
        tick;
        stop_req = 1'b0;
    endtask : test_hold

    task automatic test_loop;
        test_hold(2'h0, 1'b0, 32'h0000_c000, motor_debug_pkg::ST_ALIGN,
                  motor_debug_pkg::ST_OPEN_LOOP);
        startup_method = 2'h0;
        start_req = 1'b1;
        tick;
        start_req = 1'b0;
        phase_done = 1'b1;
        repeat (2) tick;
        phase_done = 1'b0;
        chk(seq_state_q, motor_debug_pkg::ST_CLOSED_LOOP);
        i_writer.write_word(9'h0ec, 32'h0000_8000);
        repeat (2) tick;
        chk(seq_state_q, motor_debug_pkg::ST_OPEN_LOOP);
        // Phase ends must not lift the loop while closed loop is off.
        phase_done = 1'b1;
        repeat (2) tick;
        phase_done = 1'b0;
        chk(seq_state_q, motor_debug_pkg::ST_OPEN_LOOP);
        stop_req = 1'b1;
        tick;
        stop_req = 1'b0;
    endtask : test_loop

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and hang guard.
    initial
    begin
        test_reset;
        test_speed;
        test_torque;
        test_angle;
        test_hold(2'h0, 1'b0, 32'h0000_4000, motor_debug_pkg::ST_ALIGN,
                  motor_debug_pkg::ST_OPEN_LOOP);
        test_hold(2'h1, 1'b0, 32'h0000_4000, motor_debug_pkg::ST_ALIGN,
                  motor_debug_pkg::ST_OPEN_LOOP);
        test_hold(2'h2, 1'b0, 32'h0000_1000, motor_debug_pkg::ST_POLE_DET,
                  motor_debug_pkg::ST_OPEN_LOOP);
        test_hold(2'h3, 1'b0, 32'h0000_2000, motor_debug_pkg::ST_SLOW_FIRST,
                  motor_debug_pkg::ST_OPEN_LOOP);
        test_hold(2'h0, 1'b1, 32'h0000_0800, motor_debug_pkg::ST_SPEED_DET,
                  motor_debug_pkg::ST_ALIGN);
        test_loop;
        test_reset;
        conclude;
    end

    // The tests need about 140 cycles; 3000 means something hung.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            conclude;
        end
    end

endmodule : testbench
